/* rtl/wcha_regs.svh */
`ifndef WCHA_REGS_SVH
`define WCHA_REGS_SVH

`define WCHA_SAMPLE_W 13
`define WCHA_CHAN_LAST 5'h11
`define WCHA_MAINS_I_FIRST 5'h06
`define WCHA_MAINS_I_LAST 5'h08
`define WCHA_GEN_V_FIRST 5'h09
`define WCHA_DISP_LEN 100
`define WCHA_DISP_LAST 7'h63
`define WCHA_ANA_LEN 1024
`define WCHA_ANA_LAST 10'h3FF
`define WCHA_SAMPLE_RATE 4096
`define WCHA_CLK_KHZ 100000
`define WCHA_REFRESH_MS 500
`define WCHA_REFRESH_CYC (`WCHA_REFRESH_MS * `WCHA_CLK_KHZ)
`define WCHA_PHASE_PER_HZ (65536 / `WCHA_SAMPLE_RATE)
`define WCHA_MAX_FREQ_HZ 16'h0708
`define WCHA_MAX_ORDER 5'h1F
`define WCHA_GRAPH_MIN 12'h014
`define WCHA_LEVEL_FULL 10'h3E8
`define WCHA_LEVEL_SAT 12'hFFF
`define WCHA_DISP_HALF 13'h003F
`define WCHA_FIFO_DEPTH 8

`endif

/* rtl/wcha_pkg.sv */
package wcha_pkg;
    typedef logic [4:0] wcha_chan_t;
    typedef logic signed [12:0] wcha_sample_t;
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_ACC, H_MAG, H_DIV, H_EMIT} wcha_hstate_t;
endpackage

/* rtl/wcha_stream_if.sv */
`timescale 1ns/1ps
interface wcha_stream_if #(parameter int W = 13);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* rtl/wcha_fifo.sv */
`timescale 1ns/1ps
module wcha_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input logic clk,
    input logic rst,
    wcha_stream_if.snk in_s,
    wcha_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic ready_ff;
    logic [AW:0] nxt_count;
    logic push;
    logic pop;

    assign push = in_s.valid && ready_ff;
    assign pop = out_s.valid && out_s.ready;
    assign in_s.ready = ready_ff;
    assign out_s.valid = (count_ff != '0);
    assign out_s.data = mem_ff[rd_ptr_ff];

    always_comb begin
        nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Ready is registered so the source never sees a combinational path
    always_ff @(posedge clk) begin
        if (rst) begin
            count_ff <= '0;
            ready_ff <= 1'b0;
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            count_ff <= nxt_count;
            ready_ff <= (nxt_count != (AW+1)'(DEPTH));
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_s.data;
        end
    end
endmodule

/* rtl/wcha_top.sv */
`timescale 1ns/1ps
`include "wcha_regs.svh"
// Operation
// - Eighteen channels: mains and genset phase, line voltages and phase currents.
// - Mains current channels offered only with current transformers on the load side.
// - Display buffer holds 100 samples of 13 bits at 4096 samples/s.
// - Display vertical scale chosen automatically so the trace never clips.
// - Display buffer contents readable by outside applications through the readout port.
// - Display buffer recaptured and refreshed twice each second.
// - Next and previous buttons step the selected channel, one per press; presses of both in one cycle step forward once.
// - Spectrum computed twice each second on the selected channel only.
// - Analysis buffer holds 1024 samples of 13 bits at 4096 samples/s.
// - Harmonics reported up to 1800 Hz or order 31, whichever lower.
// - Graphical view shows only harmonics above 2 percent.
// - Numeric view shows every reported harmonic at 0.1 percent resolution.
module wcha_top
    import wcha_pkg::*;
#(
    parameter int unsigned REFRESH_CYC = `WCHA_REFRESH_CYC
) (
    input logic CLOCK,
    input logic RST,
    input logic BTN_NEXT,
    input logic BTN_PREV,
    input logic CT_LOAD_SIDE,
    input logic SAMPLE_VALID,
    input wcha_sample_t SAMPLE_DATA,
    output logic SAMPLE_READY,
    input logic [10:0] FUND_FREQ,
    input logic [6:0] READ_INDEX,
    output wcha_sample_t READ_DATA,
    output wcha_chan_t CHANNEL_SEL,
    output wcha_chan_t ANALYSIS_CHANNEL,
    output logic [3:0] DISPLAY_SCALE,
    output logic DISPLAY_UPDATED,
    output logic HARM_VALID,
    output logic [4:0] HARM_ORDER,
    output logic [11:0] HARM_LEVEL,
    output logic HARM_GRAPH
);
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    function automatic logic is_mains_i(input wcha_chan_t c);
        return (c >= `WCHA_MAINS_I_FIRST) && (c <= `WCHA_MAINS_I_LAST);
    endfunction

    function automatic wcha_chan_t step_chan(input wcha_chan_t c, input logic up, input logic load);
        wcha_chan_t n;
        if (up) begin
            n = (c == `WCHA_CHAN_LAST) ? 5'h00 : c + 5'h01;
        end else begin
            n = (c == 5'h00) ? `WCHA_CHAN_LAST : c - 5'h01;
        end
        if (!load && is_mains_i(n)) begin
            n = up ? `WCHA_GEN_V_FIRST : `WCHA_MAINS_I_FIRST - 5'h01;
        end
        return n;
    endfunction

    function automatic logic [12:0] abs13(input wcha_sample_t s);
        return s[12] ? 13'(-s) : 13'(s);
    endfunction

    // Least shift that keeps the peak within half the plot height
    function automatic logic [3:0] fit_shift(input logic [12:0] p);
        logic [3:0] s;
        s = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if ((p >> i) <= `WCHA_DISP_HALF) begin
                s = 4'(i);
            end
        end
        return s;
    endfunction

    // Quarter-wave table, amplitude 255, sampled at bin centres
    function automatic logic signed [8:0] sine9(input logic [15:0] ph);
        logic [3:0] i;
        logic [7:0] v;
        i = ph[14] ? ~ph[13:10] : ph[13:10];
        unique case (i)
            4'h0: v = 8'h0D;
            4'h1: v = 8'h25;
            4'h2: v = 8'h3E;
            4'h3: v = 8'h56;
            4'h4: v = 8'h6D;
            4'h5: v = 8'h83;
            4'h6: v = 8'h98;
            4'h7: v = 8'hAB;
            4'h8: v = 8'hBD;
            4'h9: v = 8'hCD;
            4'hA: v = 8'hDB;
            4'hB: v = 8'hE7;
            4'hC: v = 8'hF0;
            4'hD: v = 8'hF7;
            4'hE: v = 8'hFC;
            4'hF: v = 8'hFF;
        endcase
        return ph[15] ? -$signed({1'b0, v}) : $signed({1'b0, v});
    endfunction

    // Alpha-max plus beta-min; error depends on each bin's re/im ratio, so ratios are approximate
    function automatic logic [31:0] mag_est(input logic signed [31:0] re, input logic signed [31:0] im);
        logic [31:0] a;
        logic [31:0] b;
        a = re[31] ? 32'(-re) : 32'(re);
        b = im[31] ? 32'(-im) : 32'(im);
        return (a > b) ? a + (b >> 1) : b + (a >> 1);
    endfunction

    function automatic logic in_limit(input logic [4:0] h, input logic [10:0] f);
        return (h != 5'h00) && (h <= `WCHA_MAX_ORDER) && (16'(h) * 16'(f) <= `WCHA_MAX_FREQ_HZ);
    endfunction

    logic [2:0] pin_raw;
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic [2:0] sync3_ff;
    logic [2:0] stable_ff;
    logic [2:0] stable_d_ff;
    logic next_press;
    logic prev_press;
    logic ct_load;
    wcha_chan_t chan_ff;
    logic [31:0] tick_cnt_ff;
    logic tick_ff;
    logic drain_rdy;
    logic pop;
    wcha_sample_t smp;
    logic disp_active_ff;
    logic [6:0] disp_idx_ff;
    logic [12:0] peak_ff;
    logic disp_done_ff;
    logic [3:0] scale_ff;
    wcha_sample_t disp_mem_ff [`WCHA_DISP_LEN];
    wcha_sample_t read_data_ff;
    logic ana_pending_ff;
    logic ana_active_ff;
    logic [9:0] ana_idx_ff;
    logic ana_done_ff;
    wcha_chan_t ana_chan_ff;
    wcha_sample_t ana_mem_ff [`WCHA_ANA_LEN];
    wcha_hstate_t hstate_ff;
    logic dft_busy;
    logic [4:0] order_ff;
    logic [10:0] freq_ff;
    logic [9:0] k_ff;
    logic [15:0] phase_ff;
    logic [15:0] step_ff;
    logic signed [31:0] acc_re_ff;
    logic signed [31:0] acc_im_ff;
    logic [31:0] mag_ff;
    logic [31:0] fund_ff;
    logic [43:0] rem_ff;
    logic [11:0] quo_ff;
    logic [3:0] bit_ff;
    logic [31:0] mag_now;
    logic [31:0] den_now;
    logic [43:0] num_now;
    wcha_sample_t ana_smp;
    logic harm_valid_ff;
    logic [4:0] harm_order_ff;
    logic [11:0] harm_level_ff;
    logic harm_graph_ff;

    wcha_stream_if #(.W(`WCHA_SAMPLE_W)) fe_s ();
    wcha_stream_if #(.W(`WCHA_SAMPLE_W)) cap_s ();

    wcha_fifo #(
        .WIDTH(`WCHA_SAMPLE_W),
        .DEPTH(`WCHA_FIFO_DEPTH)
    ) u_fifo (
        .clk(CLOCK),
        .rst(RST),
        .in_s(fe_s),
        .out_s(cap_s)
    );

    assign fe_s.valid = SAMPLE_VALID;
    assign fe_s.data = SAMPLE_DATA;
    assign SAMPLE_READY = fe_s.ready;
    // Hold samples back while a due analysis capture waits for the transform
    assign drain_rdy = !(ana_pending_ff && dft_busy);
    assign cap_s.ready = drain_rdy;
    assign pop = cap_s.valid && drain_rdy;
    assign smp = cap_s.data;

    assign READ_DATA = read_data_ff;
    assign CHANNEL_SEL = chan_ff;
    assign ANALYSIS_CHANNEL = ana_chan_ff;
    assign DISPLAY_SCALE = scale_ff;
    assign DISPLAY_UPDATED = disp_done_ff;
    assign HARM_VALID = harm_valid_ff;
    assign HARM_ORDER = harm_order_ff;
    assign HARM_LEVEL = harm_level_ff;
    assign HARM_GRAPH = harm_graph_ff;

    // Pins: three stages, a level counts once stages two and three agree
    assign pin_raw = {CT_LOAD_SIDE, BTN_PREV, BTN_NEXT};
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            sync3_ff <= 3'h0;
            stable_ff <= 3'h0;
            stable_d_ff <= 3'h0;
        end else begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            stable_ff <= ((sync2_ff ~^ sync3_ff) & sync3_ff) | ((sync2_ff ^ sync3_ff) & stable_ff);
            stable_d_ff <= stable_ff;
        end
    end
    assign next_press = stable_ff[0] && !stable_d_ff[0];
    assign prev_press = stable_ff[1] && !stable_d_ff[1];
    assign ct_load = stable_ff[2];

    // Next wins if both buttons land in one cycle
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            chan_ff <= 5'h00;
        end else if (next_press) begin
            chan_ff <= step_chan(chan_ff, 1'b1, ct_load);
        end else if (prev_press) begin
            chan_ff <= step_chan(chan_ff, 1'b0, ct_load);
        end else if (!ct_load && is_mains_i(chan_ff)) begin
            chan_ff <= `WCHA_GEN_V_FIRST;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            tick_cnt_ff <= 32'h0;
            tick_ff <= 1'b0;
        end else if (tick_cnt_ff == 32'(REFRESH_CYC - 1)) begin
            tick_cnt_ff <= 32'h0;
            tick_ff <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h1;
            tick_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            disp_active_ff <= 1'b0;
            disp_idx_ff <= 7'h00;
            peak_ff <= 13'h0000;
            disp_done_ff <= 1'b0;
        end else begin
            disp_done_ff <= 1'b0;
            if (tick_ff) begin
                disp_active_ff <= 1'b1;
                disp_idx_ff <= 7'h00;
                peak_ff <= 13'h0000;
            end else if (disp_active_ff && pop) begin
                disp_idx_ff <= disp_idx_ff + 7'h01;
                if (abs13(smp) > peak_ff) begin
                    peak_ff <= abs13(smp);
                end
                if (disp_idx_ff == `WCHA_DISP_LAST) begin
                    disp_active_ff <= 1'b0;
                    disp_done_ff <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            scale_ff <= 4'h0;
        end else if (disp_active_ff && pop && disp_idx_ff == `WCHA_DISP_LAST) begin
            scale_ff <= fit_shift((abs13(smp) > peak_ff) ? abs13(smp) : peak_ff);
        end
    end

    // Readout sees the frame as it fills; software polls after the update pulse
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            for (int i = 0; i < `WCHA_DISP_LEN; i++) begin
                disp_mem_ff[i] <= 13'h0000;
            end
            read_data_ff <= 13'h0000;
        end else begin
            if (disp_active_ff && pop) begin
                disp_mem_ff[disp_idx_ff] <= smp;
            end
            read_data_ff <= (READ_INDEX <= `WCHA_DISP_LAST) ? disp_mem_ff[READ_INDEX] : 13'h0000;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ana_pending_ff <= 1'b0;
            ana_active_ff <= 1'b0;
            ana_idx_ff <= 10'h000;
            ana_done_ff <= 1'b0;
            ana_chan_ff <= 5'h00;
        end else begin
            ana_done_ff <= 1'b0;
            if (ana_pending_ff && !dft_busy) begin
                ana_pending_ff <= 1'b0;
                ana_active_ff <= 1'b1;
                ana_idx_ff <= 10'h000;
                ana_chan_ff <= chan_ff;
            end else if (ana_active_ff && pop) begin
                ana_idx_ff <= ana_idx_ff + 10'h001;
                if (ana_idx_ff == `WCHA_ANA_LAST) begin
                    ana_active_ff <= 1'b0;
                    ana_done_ff <= 1'b1;
                end
            end
            if (tick_ff) begin
                ana_pending_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (ana_active_ff && pop) begin
            ana_mem_ff[ana_idx_ff] <= smp;
        end
    end

    assign dft_busy = (hstate_ff != H_IDLE);
    assign ana_smp = ana_mem_ff[k_ff];
    assign mag_now = mag_est(acc_re_ff, acc_im_ff);
    assign den_now = (order_ff == 5'h01) ? mag_now : fund_ff;
    assign num_now = 44'(mag_now) * 44'(`WCHA_LEVEL_FULL);

    // One bin per order, correlated at the exact harmonic frequency
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            hstate_ff <= H_IDLE;
            order_ff <= 5'h00;
            freq_ff <= 11'h000;
            k_ff <= 10'h000;
            phase_ff <= 16'h0000;
            step_ff <= 16'h0000;
            acc_re_ff <= 32'sh0;
            acc_im_ff <= 32'sh0;
            mag_ff <= 32'h0;
            fund_ff <= 32'h0;
            rem_ff <= 44'h0;
            quo_ff <= 12'h000;
            bit_ff <= 4'h0;
        end else begin
            unique case (hstate_ff)
                H_IDLE: begin
                    if (ana_done_ff) begin
                        order_ff <= 5'h01;
                        freq_ff <= FUND_FREQ;
                        hstate_ff <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    k_ff <= 10'h000;
                    phase_ff <= 16'h0000;
                    acc_re_ff <= 32'sh0;
                    acc_im_ff <= 32'sh0;
                    step_ff <= 16'(16'(order_ff) * 16'(freq_ff) * 16'(`WCHA_PHASE_PER_HZ));
                    hstate_ff <= in_limit(order_ff, freq_ff) ? H_ACC : H_IDLE;
                end
                H_ACC: begin
                    acc_re_ff <= acc_re_ff + 32'(ana_smp) * 32'(sine9(phase_ff + 16'h4000));
                    acc_im_ff <= acc_im_ff + 32'(ana_smp) * 32'(sine9(phase_ff));
                    phase_ff <= phase_ff + step_ff;
                    k_ff <= k_ff + 10'h001;
                    if (k_ff == `WCHA_ANA_LAST) begin
                        hstate_ff <= H_MAG;
                    end
                end
                H_MAG: begin
                    mag_ff <= mag_now;
                    if (order_ff == 5'h01) begin
                        fund_ff <= mag_now;
                    end
                    rem_ff <= num_now;
                    quo_ff <= 12'h000;
                    bit_ff <= 4'hB;
                    if (den_now == 32'h0) begin
                        hstate_ff <= H_EMIT;
                    end else if (num_now >= (44'(den_now) << 12)) begin
                        quo_ff <= `WCHA_LEVEL_SAT;
                        hstate_ff <= H_EMIT;
                    end else begin
                        hstate_ff <= H_DIV;
                    end
                end
                H_DIV: begin
                    if (rem_ff >= (44'(fund_ff) << bit_ff)) begin
                        rem_ff <= rem_ff - (44'(fund_ff) << bit_ff);
                        quo_ff <= quo_ff | (12'h001 << bit_ff);
                    end
                    bit_ff <= bit_ff - 4'h1;
                    if (bit_ff == 4'h0) begin
                        hstate_ff <= H_EMIT;
                    end
                end
                H_EMIT: begin
                    order_ff <= order_ff + 5'h01;
                    hstate_ff <= H_SETUP;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            harm_valid_ff <= 1'b0;
            harm_order_ff <= 5'h00;
            harm_level_ff <= 12'h000;
            harm_graph_ff <= 1'b0;
        end else begin
            harm_valid_ff <= (hstate_ff == H_EMIT);
            if (hstate_ff == H_EMIT) begin
                harm_order_ff <= order_ff;
                harm_level_ff <= quo_ff;
                harm_graph_ff <= (quo_ff > `WCHA_GRAPH_MIN);
            end
        end
    end

    a_chan_range: assert property (chan_ff <= `WCHA_CHAN_LAST)
        else $error("channel index out of range");

    a_mains_i_hidden: assert property (!ct_load && !$past(ct_load) |-> !is_mains_i(chan_ff))
        else $error("mains current channel selected without load-side transformers");

    a_disp_frame_len: assert property (disp_done_ff |-> $past(disp_idx_ff) == `WCHA_DISP_LAST)
        else $error("display frame did not hold 100 samples");

    a_scale_no_clip: assert property (disp_done_ff |-> ((peak_ff >> scale_ff) <= `WCHA_DISP_HALF)
        && (scale_ff == 4'h0 || (peak_ff >> (scale_ff - 4'h1)) > `WCHA_DISP_HALF))
        else $error("display scale clips or is not the least that fits");

    a_readout_data: assert property (!disp_active_ff && READ_INDEX <= `WCHA_DISP_LAST
        |=> READ_DATA == disp_mem_ff[$past(READ_INDEX)])
        else $error("readout does not return the display buffer word");

    a_refresh_period: assert property (tick_ff |-> tick_cnt_ff == 32'h0
        && $past(tick_cnt_ff) == 32'(REFRESH_CYC - 1))
        else $error("refresh tick off its half-second period");

    a_button_step: assert property (next_press |=> chan_ff == step_chan($past(chan_ff), 1'b1, $past(ct_load)))
        else $error("next button did not step one channel");

    a_dft_start: assert property (ana_done_ff |=> hstate_ff == H_SETUP && order_ff == 5'h01
        && ANALYSIS_CHANNEL == $past(ana_chan_ff))
        else $error("transform did not start on the captured channel");

    a_ana_frame_len: assert property (ana_done_ff |-> $past(ana_idx_ff) == `WCHA_ANA_LAST)
        else $error("analysis frame did not hold 1024 samples");

    a_harm_limit: assert property (HARM_VALID |-> HARM_ORDER <= `WCHA_MAX_ORDER
        && 16'(HARM_ORDER) * 16'(freq_ff) <= `WCHA_MAX_FREQ_HZ)
        else $error("harmonic reported past the frequency or order limit");

    a_graph_gate: assert property (HARM_VALID |-> HARM_GRAPH == (HARM_LEVEL > `WCHA_GRAPH_MIN))
        else $error("graph flag disagrees with the 2 percent threshold");

    a_level_floor: assert property (HARM_VALID && fund_ff != 32'h0 && HARM_LEVEL != `WCHA_LEVEL_SAT
        |-> 44'(HARM_LEVEL) * 44'(fund_ff) <= 44'(mag_ff) * 44'(`WCHA_LEVEL_FULL)
        && (44'(HARM_LEVEL) + 44'h1) * 44'(fund_ff) > 44'(mag_ff) * 44'(`WCHA_LEVEL_FULL))
        else $error("harmonic level is not the 0.1 percent quotient");

    a_fund_full: assert property (HARM_VALID && HARM_ORDER == 5'h01 && fund_ff != 32'h0
        |-> HARM_LEVEL == `WCHA_LEVEL_FULL)
        else $error("fundamental does not read 100.0 percent");
endmodule

/* verif/wcha_front_model.sv */
`timescale 1ns/1ps
module wcha_front_model
    import wcha_pkg::*;
#(
    parameter int AMP = 32'h3E8
) (
    input logic clk,
    input logic rst,
    input logic square,
    input logic ready,
    output logic valid,
    output wcha_sample_t data
);
    logic [3:0] phase_ff = 4'h0;
    logic run_ff = 1'b0;
    assign valid = run_ff;
    // Word held until accepted, so a stalled block loses nothing
    always @(posedge clk) begin
        if (rst) begin
            run_ff <= 1'b0;
            phase_ff <= 4'h0;
        end else begin
            run_ff <= 1'b1;
            if (run_ff && ready) begin
                phase_ff <= (phase_ff == 4'h7) ? 4'h0 : phase_ff + 4'h1;
            end
        end
    end
    // Eight words per period: 512 Hz, whole periods in a frame, so no leakage
    assign data = (!square || phase_ff < 4'h4) ? wcha_sample_t'(AMP) : -wcha_sample_t'(AMP);
endmodule

/* verif/wcha_top_tb.sv */
`timescale 1ns/1ps
module wcha_top_tb;
    import wcha_pkg::*;
    localparam int REFRESH = 6000;
    logic CLOCK, RST, BTN_NEXT, BTN_PREV, CT_LOAD_SIDE, SAMPLE_VALID, SAMPLE_READY, square;
    logic DISPLAY_UPDATED, HARM_VALID, HARM_GRAPH;
    logic [10:0] FUND_FREQ;
    logic [6:0] READ_INDEX;
    logic [3:0] DISPLAY_SCALE;
    logic [4:0] HARM_ORDER;
    logic [11:0] HARM_LEVEL;
    wcha_sample_t SAMPLE_DATA, READ_DATA;
    wcha_chan_t CHANNEL_SEL, ANALYSIS_CHANNEL;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int upd_at[$];

    wcha_top #(.REFRESH_CYC(REFRESH)) u_wcha_top (.CLOCK(CLOCK), .RST(RST), .BTN_NEXT(BTN_NEXT),
        .BTN_PREV(BTN_PREV), .CT_LOAD_SIDE(CT_LOAD_SIDE), .SAMPLE_VALID(SAMPLE_VALID),
        .SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_READY(SAMPLE_READY), .FUND_FREQ(FUND_FREQ),
        .READ_INDEX(READ_INDEX), .READ_DATA(READ_DATA), .CHANNEL_SEL(CHANNEL_SEL),
        .ANALYSIS_CHANNEL(ANALYSIS_CHANNEL), .DISPLAY_SCALE(DISPLAY_SCALE),
        .DISPLAY_UPDATED(DISPLAY_UPDATED), .HARM_VALID(HARM_VALID), .HARM_ORDER(HARM_ORDER),
        .HARM_LEVEL(HARM_LEVEL), .HARM_GRAPH(HARM_GRAPH));
    wcha_front_model u_wcha_front_model (.clk(CLOCK), .rst(RST), .square(square),
        .ready(SAMPLE_READY), .valid(SAMPLE_VALID), .data(SAMPLE_DATA));

    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end
    always @(posedge CLOCK) cyc++;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic press(input logic fwd);
        if (fwd) BTN_NEXT = 1'b1;
        else BTN_PREV = 1'b1;
        repeat (8) @(negedge CLOCK);
        BTN_NEXT = 1'b0;
        BTN_PREV = 1'b0;
        repeat (8) @(negedge CLOCK);
    endtask

    task automatic wait_update();
        int n;
        n = 0;
        @(negedge CLOCK);
        while (DISPLAY_UPDATED !== 1'b1 && n < 2 * REFRESH) begin
            @(negedge CLOCK);
            n++;
        end
        check("display pulse", DISPLAY_UPDATED, 16'h0001);
        upd_at.push_back(cyc);
    endtask

    task automatic test_channels();
        press(1'b0);
        check("wrap back", CHANNEL_SEL, 16'h0011);
        press(1'b1);
        check("wrap fwd", CHANNEL_SEL, 16'h0000);
        repeat (5) press(1'b1);
        check("step", CHANNEL_SEL, 16'h0005);
        press(1'b1);
        check("skip mains I", CHANNEL_SEL, 16'h0009);
        press(1'b0);
        check("skip back", CHANNEL_SEL, 16'h0005);
        CT_LOAD_SIDE = 1'b1;
        repeat (8) @(negedge CLOCK);
        press(1'b1);
        check("mains I on", CHANNEL_SEL, 16'h0006);
        CT_LOAD_SIDE = 1'b0;
        repeat (10) @(negedge CLOCK);
        check("mains I left", CHANNEL_SEL, 16'h0009);
    endtask

    task automatic test_display();
        logic [6:0] idx[4] = '{7'h00, 7'h32, 7'h63, 7'h64};
        wait_update();
        check("scale", DISPLAY_SCALE, 16'h0004);
        foreach (idx[i]) begin
            READ_INDEX = idx[i];
            @(negedge CLOCK);
            check("read", READ_DATA, (idx[i] < 7'h64) ? 16'h03E8 : 16'h0000);
        end
        wait_update();
        check("refresh span", 16'(upd_at[1] - upd_at[0]), 16'(REFRESH));
        square = 1'b1;
    endtask

    task automatic test_harmonics();
        int n;
        n = 0;
        wait_update();
        check("analysed chan", ANALYSIS_CHANNEL, 16'h0009);
        repeat (5500) begin
            @(negedge CLOCK);
            if (HARM_VALID === 1'b1) begin
                n++;
                check("order", HARM_ORDER, 16'(n));
                check("graph", HARM_GRAPH, 16'(HARM_LEVEL > 12'h014));
                if (n == 1) check("fund level", HARM_LEVEL, 16'h03E8);
                if (n == 2) check("even level", HARM_LEVEL, 16'h0000);
                if (n == 2) check("even graph", HARM_GRAPH, 16'h0000);
                if (n == 3) begin
                    check("third level", 16'(HARM_LEVEL > 12'h12C && HARM_LEVEL < 12'h1F4), 16'h0001);
                    check("third graph", HARM_GRAPH, 16'h0001);
                end
            end
        end
        check("orders", 16'(n), 16'h0003);
    endtask

    initial begin
        repeat (40000) @(posedge CLOCK);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        RST = 1'b1;
        BTN_NEXT = 1'b0;
        BTN_PREV = 1'b0;
        CT_LOAD_SIDE = 1'b0;
        square = 1'b0;
        FUND_FREQ = 11'h200;
        READ_INDEX = 7'h00;
        repeat (6) @(negedge CLOCK);
        check("reset chan", CHANNEL_SEL, 16'h0000);
        check("reset ready", SAMPLE_READY, 16'h0000);
        RST = 1'b0;
        test_channels();
        test_display();
        test_harmonics();
        tally_and_finish();
    end
endmodule
